/* File: rtl/pin_route.sv */
// one selector: picks a remappable pin through the table and registers it
module pin_route #(
    parameter remap_pkg::pin_map_t PIN_MAP = remap_pkg::PIN_MAP_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [remap_pkg::PIN_COUNT-1:0] remappable_pin,
    input wire logic [7:0] sel,
    output logic route_q
);
    logic [7:0] entry;
    logic hit;

    assign entry = PIN_MAP[sel];
    assign hit = entry < 8'(remap_pkg::PIN_COUNT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_q <= 1'b0;
        end else if (hit) begin
            route_q <= remappable_pin[entry[5:0]];
        end else begin
            route_q <= 1'b0;
        end
    end

    a_route_mapped_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        hit |=> route_q == $past(remappable_pin[entry[5:0]]))
        else $error("mapped selector did not follow its pin");

    a_route_unmapped_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !hit |=> !route_q)
        else $error("unmapped selector drove an active level");

endmodule : pin_route

/* File: rtl/remap_input_select.sv */
// input remapping selectors behind an AXI4-Lite slave
// Operation
// - the upper byte of each capture 4..8 register picks the pin for that capture input.
// - the lower byte of the same register picks the pin for that unit's timer clock input.
// - one register routes fault B from its upper byte and fault A from its lower byte.
// - PWM inputs 8 and 10 come from lower bytes, 9 and 11 from upper bytes of two registers.
// - encoder 1 phase B is picked by the upper byte and phase A by the lower byte.
// - encoder 1 home is picked by the upper byte and index by the lower byte.
// - every selector bit is read/write and clears to zero at reset.
// - while the lock bit is set all selector writes are ignored; while clear they land.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
module remap_input_select #(
    parameter remap_pkg::pin_map_t PIN_MAP = remap_pkg::PIN_MAP_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [remap_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [remap_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [remap_pkg::PIN_COUNT-1:0] remappable_pin,
    output remap_pkg::periph_in_t periph_in,
    output logic remap_lock
);

    function automatic logic [3:0] addr_index(input logic [7:0] a);
        case ({a[7:2], 2'b00})
            remap_pkg::OFF_CAP4_TMR4: addr_index = 4'h0;
            remap_pkg::OFF_CAP5_TMR5: addr_index = 4'h1;
            remap_pkg::OFF_CAP6_TMR6: addr_index = 4'h2;
            remap_pkg::OFF_CAP7_TMR7: addr_index = 4'h3;
            remap_pkg::OFF_CAP8_TMR8: addr_index = 4'h4;
            remap_pkg::OFF_FAULT: addr_index = 4'h5;
            remap_pkg::OFF_PWM_8_9: addr_index = 4'h6;
            remap_pkg::OFF_PWM_10_11: addr_index = 4'h7;
            remap_pkg::OFF_ENC_PHASE: addr_index = 4'h8;
            remap_pkg::OFF_ENC_IDX_HOME: addr_index = 4'h9;
            remap_pkg::OFF_LOCK: addr_index = remap_pkg::IDX_LOCK;
            remap_pkg::OFF_KEY: addr_index = remap_pkg::IDX_KEY;
            default: addr_index = remap_pkg::IDX_NONE;
        endcase
    endfunction : addr_index

    function automatic logic is_sel_reg(input logic [3:0] idx);
        return idx < 4'(remap_pkg::REG_COUNT);
    endfunction : is_sel_reg

    // reference model of one route, used only by the checks below
    function automatic logic expect_bit(input logic [remap_pkg::PIN_COUNT-1:0] p,
                                        input logic [7:0] s);
        logic [7:0] e;
        e = PIN_MAP[s];
        if (e < 8'(remap_pkg::PIN_COUNT)) begin
            return p[e[5:0]];
        end
        return 1'b0;
    endfunction : expect_bit

    logic [15:0] sel_q [remap_pkg::REG_COUNT];
    logic lock_q;
    logic armed;

    logic awready_q;
    logic wready_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic aw_take;
    logic w_take;
    logic wr_go;
    logic [3:0] wr_idx;
    logic key_wr;
    logic other_wr;
    logic lock_wr;
    logic ar_take;
    logic [3:0] rd_idx;
    logic [remap_pkg::SEL_COUNT-1:0] route;

    assign aw_take = awvalid && awready_q;
    assign w_take = wvalid && wready_q;
    assign wr_go = aw_held_q && w_held_q && !bvalid_q;
    assign wr_idx = addr_index(awaddr_q);
    assign key_wr = wr_go && wr_idx == remap_pkg::IDX_KEY && wstrb_q[1:0] == 2'b11;
    assign other_wr = wr_go && !key_wr;
    assign lock_wr = wr_go && wr_idx == remap_pkg::IDX_LOCK && wstrb_q[1];
    assign ar_take = arvalid && arready_q;
    assign rd_idx = addr_index(araddr);

    // write address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q <= awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    // ready drops once a beat is held and returns after the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end else begin
            if (aw_take) begin
                awready_q <= 1'b0;
            end else if (bvalid_q && bready) begin
                awready_q <= 1'b1;
            end
            if (w_take) begin
                wready_q <= 1'b0;
            end else if (bvalid_q && bready) begin
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= remap_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_idx == remap_pkg::IDX_NONE) ?
                remap_pkg::RESP_SLVERR : remap_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // a locked write still gets OKAY; software sees the refusal only by reading back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < remap_pkg::REG_COUNT; i++) begin
                sel_q[i] <= remap_pkg::SEL_RESET;
            end
        end else if (wr_go && is_sel_reg(wr_idx) && !lock_q) begin
            if (wstrb_q[0]) begin
                sel_q[wr_idx] <= {sel_q[wr_idx][15:8], wdata_q[7:0]};
            end
            if (wstrb_q[1]) begin
                sel_q[wr_idx] <= {wdata_q[15:8], wstrb_q[0] ? wdata_q[7:0] : sel_q[wr_idx][7:0]};
            end
        end
    end

    unlock_seq u_unlock (
        .aclk(aclk),
        .aresetn(aresetn),
        .key_wr(key_wr),
        .key_data(wdata_q[15:0]),
        .other_wr(other_wr),
        .armed_q(armed)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_q <= remap_pkg::LOCK_RESET;
        end else if (lock_wr && armed) begin
            lock_q <= wdata_q[remap_pkg::LOCK_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= remap_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= (rd_idx == remap_pkg::IDX_NONE) ?
                remap_pkg::RESP_SLVERR : remap_pkg::RESP_OKAY;
            if (is_sel_reg(rd_idx)) begin
                rdata_q <= {16'h0000, sel_q[rd_idx]};
            end else if (rd_idx == remap_pkg::IDX_LOCK) begin
                rdata_q <= 32'(lock_q) << remap_pkg::LOCK_BIT;
            end else if (rd_idx == remap_pkg::IDX_KEY) begin
                rdata_q <= 32'(armed) << remap_pkg::ARMED_BIT;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // selector k sits in register k/2, lower byte for even k, upper byte for odd k
    for (genvar k = 0; k < remap_pkg::SEL_COUNT; k++) begin : g_route
        pin_route #(
            .PIN_MAP(PIN_MAP)
        ) u_route (
            .aclk(aclk),
            .aresetn(aresetn),
            .remappable_pin(remappable_pin),
            .sel(sel_q[k / 2][(k % 2) * 8 +: 8]),
            .route_q(route[k])
        );
    end

    for (genvar u = 0; u < 5; u++) begin : g_ccp
        assign periph_in.capture[u] = route[2 * u + 1];
        assign periph_in.timer_clk[u] = route[2 * u];
    end
    assign periph_in.fault_a = route[10];
    assign periph_in.fault_b = route[11];
    assign periph_in.pwm8 = route[12];
    assign periph_in.pwm9 = route[13];
    assign periph_in.pwm10 = route[14];
    assign periph_in.pwm11 = route[15];
    assign periph_in.enc_a = route[16];
    assign periph_in.enc_b = route[17];
    assign periph_in.enc_index = route[18];
    assign periph_in.enc_home = route[19];

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign remap_lock = lock_q;

    a_capture4_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.capture[0] == $past(expect_bit(remappable_pin, sel_q[0][15:8])))
        else $error("capture 4 input does not follow its selector");

    a_timer8_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.timer_clk[4] == $past(expect_bit(remappable_pin, sel_q[4][7:0])))
        else $error("timer 8 clock input does not follow its selector");

    a_fault_b_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.fault_b == $past(expect_bit(remappable_pin, sel_q[5][15:8])))
        else $error("fault B input does not follow its selector");

    a_pwm10_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.pwm10 == $past(expect_bit(remappable_pin, sel_q[7][7:0])))
        else $error("pwm input 10 does not follow its selector");

    a_enc_phase_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.enc_b == $past(expect_bit(remappable_pin, sel_q[8][15:8]))
            && periph_in.enc_a == $past(expect_bit(remappable_pin, sel_q[8][7:0])))
        else $error("encoder phase inputs do not follow their selectors");

    a_enc_home_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.enc_home == $past(expect_bit(remappable_pin, sel_q[9][15:8])))
        else $error("encoder home input does not follow its selector");

    a_enc_index_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.enc_index == $past(expect_bit(remappable_pin, sel_q[9][7:0])))
        else $error("encoder index input does not follow its selector");

    a_capture8_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.capture[4] == $past(expect_bit(remappable_pin, sel_q[4][15:8])))
        else $error("capture 8 input does not follow its selector");

    a_timer4_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.timer_clk[0] == $past(expect_bit(remappable_pin, sel_q[0][7:0])))
        else $error("timer 4 clock input does not follow its selector");

    a_fault_a_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.fault_a == $past(expect_bit(remappable_pin, sel_q[5][7:0])))
        else $error("fault A input does not follow its selector");

    a_pwm8_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.pwm8 == $past(expect_bit(remappable_pin, sel_q[6][7:0])))
        else $error("pwm input 8 does not follow its selector");

    a_pwm_odd_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> periph_in.pwm9 == $past(expect_bit(remappable_pin, sel_q[6][15:8]))
            && periph_in.pwm11 == $past(expect_bit(remappable_pin, sel_q[7][15:8])))
        else $error("pwm inputs 9 and 11 do not follow their selectors");

    a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid_q && !rready |=> rvalid_q && $stable(rdata_q) && $stable(rresp_q))
        else $error("read data dropped before it was taken");

    a_sel_reset_zero: assert property (@(posedge aclk)
        !aresetn |=> sel_q[0] == 16'h0000 && sel_q[9] == 16'h0000 && !lock_q)
        else $error("selectors not cleared by reset");

    a_locked_sel_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_q |=> $stable(sel_q[3]) && $stable(sel_q[6]))
        else $error("selector changed while locked");

    a_unlocked_sel_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && !lock_q && wr_idx == 4'h6 && wstrb_q[1:0] == 2'b11
        |=> sel_q[6] == $past(wdata_q[15:0]))
        else $error("unlocked selector write did not land");

    a_lock_needs_key: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_wr && !armed |=> lock_q == $past(lock_q))
        else $error("lock changed without the unlock sequence");

    a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped before it was taken");

endmodule : remap_input_select

/* File: rtl/remap_pkg.sv */
// shared constants, types and the default selector-to-pin table for the input remap block
package remap_pkg;

    localparam int REG_COUNT = 10;
    localparam int SEL_COUNT = 20;
    localparam int PIN_COUNT = 64;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_CAP4_TMR4 = 8'h00;
    localparam logic [7:0] OFF_CAP5_TMR5 = 8'h04;
    localparam logic [7:0] OFF_CAP6_TMR6 = 8'h08;
    localparam logic [7:0] OFF_CAP7_TMR7 = 8'h0c;
    localparam logic [7:0] OFF_CAP8_TMR8 = 8'h10;
    localparam logic [7:0] OFF_FAULT = 8'h14;
    localparam logic [7:0] OFF_PWM_8_9 = 8'h18;
    localparam logic [7:0] OFF_PWM_10_11 = 8'h1c;
    localparam logic [7:0] OFF_ENC_PHASE = 8'h20;
    localparam logic [7:0] OFF_ENC_IDX_HOME = 8'h24;
    localparam logic [7:0] OFF_LOCK = 8'h28;
    localparam logic [7:0] OFF_KEY = 8'h2c;

    // decoded register indices beyond the ten selector registers
    localparam logic [3:0] IDX_LOCK = 4'ha;
    localparam logic [3:0] IDX_KEY = 4'hb;
    localparam logic [3:0] IDX_NONE = 4'hf;

    localparam int LOCK_BIT = 11;
    localparam int ARMED_BIT = 0;
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic [15:0] UNLOCK_KEY1 = 16'h5a3c;
    localparam logic [15:0] UNLOCK_KEY2 = 16'hc3a5;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    localparam logic [7:0] PIN_NONE = 8'hff;

    typedef logic [255:0][7:0] pin_map_t;

    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_t;

    typedef struct packed {
        logic enc_home;
        logic enc_index;
        logic enc_b;
        logic enc_a;
        logic pwm11;
        logic pwm10;
        logic pwm9;
        logic pwm8;
        logic fault_b;
        logic fault_a;
        logic [4:0] timer_clk;
        logic [4:0] capture;
    } periph_in_t;

    // value 0 selects nothing, so the reset state routes every input inactive
    function automatic pin_map_t default_pin_map();
        pin_map_t m;
        for (int v = 0; v < 256; v++) begin
            if (v >= 1 && v <= PIN_COUNT) begin
                m[v] = 8'(v - 1);
            end else begin
                m[v] = PIN_NONE;
            end
        end
        return m;
    endfunction : default_pin_map

    localparam pin_map_t PIN_MAP_DEFAULT = default_pin_map();

endpackage : remap_pkg

/* File: rtl/unlock_seq.sv */
// two-key unlock sequence that arms one write of the lock register
module unlock_seq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic key_wr,
    input wire logic [15:0] key_data,
    input wire logic other_wr,
    output logic armed_q
);
    remap_pkg::key_state_t state_q;

    // any other write breaks the sequence, so a stray store cannot leave it armed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= remap_pkg::KEY_IDLE;
        end else if (other_wr) begin
            state_q <= remap_pkg::KEY_IDLE;
        end else if (key_wr) begin
            case (state_q)
                remap_pkg::KEY_IDLE: begin
                    state_q <= (key_data == remap_pkg::UNLOCK_KEY1) ?
                        remap_pkg::KEY_HALF : remap_pkg::KEY_IDLE;
                end
                remap_pkg::KEY_HALF: begin
                    state_q <= (key_data == remap_pkg::UNLOCK_KEY2) ?
                        remap_pkg::KEY_ARMED : remap_pkg::KEY_IDLE;
                end
                default: begin
                    state_q <= remap_pkg::KEY_IDLE;
                end
            endcase
        end
    end

    assign armed_q = (state_q == remap_pkg::KEY_ARMED);

endmodule : unlock_seq

/* File: tb/pin_bank.sv */
// model of the remappable device pins: levels stand until a new pattern is loaded
module pin_bank (
    input wire logic aclk,
    input wire logic load,
    input wire logic [remap_pkg::PIN_COUNT-1:0] level,
    output logic [remap_pkg::PIN_COUNT-1:0] remappable_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial remappable_pin = '0;
    // pins change only at an edge, as the routes expect synchronous inputs
    always @(posedge aclk) begin
        if (load) begin
            remappable_pin <= level;
        end
    end
endmodule : pin_bank

/* File: tb/remappable_input_selector_bench.sv */
// self-checking bench for the input remap selectors
module remappable_input_selector_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, load, remap_lock;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, idx;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [63:0] level, remappable_pin;
    logic [15:0] val;
    logic [15:0] shadow [10];
    logic [15:0] corner [4] = '{16'h4001, 16'hff41, 16'h0040, 16'h0100};
    remap_pkg::periph_in_t periph_in, ep;
    int n_fail, n_checks, seed;

    remap_input_select uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .remappable_pin(remappable_pin), .periph_in(periph_in), .remap_lock(remap_lock));
    pin_bank bank (.aclk(aclk), .load(load), .level(level), .remappable_pin(remappable_pin));

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // both channels offered together, each released at its own handshake edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready && !aw_ok) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        // bready waits for bvalid so the slave has to hold its response a cycle
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    function automatic logic pick(input logic [7:0] v);
        return (v >= 8'h01 && v <= 8'h40) ? remappable_pin[8'(v - 8'h01)] : 1'b0;
    endfunction : pick

    function automatic remap_pkg::periph_in_t expect_routes();
        remap_pkg::periph_in_t e;
        for (int j = 0; j < 5; j++) begin
            e.capture[j] = pick(shadow[j][15:8]);
            e.timer_clk[j] = pick(shadow[j][7:0]);
        end
        e.fault_b = pick(shadow[5][15:8]);
        e.fault_a = pick(shadow[5][7:0]);
        e.pwm9 = pick(shadow[6][15:8]);
        e.pwm8 = pick(shadow[6][7:0]);
        e.pwm11 = pick(shadow[7][15:8]);
        e.pwm10 = pick(shadow[7][7:0]);
        e.enc_b = pick(shadow[8][15:8]);
        e.enc_a = pick(shadow[8][7:0]);
        e.enc_home = pick(shadow[9][15:8]);
        e.enc_index = pick(shadow[9][7:0]);
        return e;
    endfunction : expect_routes

    // load pins, then let the one-cycle route lag pass before looking
    task automatic pins_and_routes(input logic [63:0] v);
        level <= v;
        load <= 1'b1;
        @(posedge aclk);
        load <= 1'b0;
        repeat (2) @(posedge aclk);
        ep = expect_routes();
        check("capture", 32'(periph_in.capture), 32'(ep.capture));
        check("timer clk", 32'(periph_in.timer_clk), 32'(ep.timer_clk));
        check("fault", 32'({periph_in.fault_b, periph_in.fault_a}),
              32'({ep.fault_b, ep.fault_a}));
        check("pwm", 32'({periph_in.pwm11, periph_in.pwm10, periph_in.pwm9, periph_in.pwm8}),
              32'({ep.pwm11, ep.pwm10, ep.pwm9, ep.pwm8}));
        check("phase", 32'({periph_in.enc_b, periph_in.enc_a}), 32'({ep.enc_b, ep.enc_a}));
        check("home idx", 32'({periph_in.enc_home, periph_in.enc_index}),
              32'({ep.enc_home, ep.enc_index}));
    endtask : pins_and_routes

    // software side of the unlock sequence precedes the lock write made by this task
    task automatic set_lock(input logic b);
        axi_write(remap_pkg::OFF_KEY, {16'h0, remap_pkg::UNLOCK_KEY1}, 4'h3, rs);
        axi_write(remap_pkg::OFF_KEY, {16'h0, remap_pkg::UNLOCK_KEY2}, 4'h3, rs);
        axi_read(remap_pkg::OFF_KEY, rd, rs);
        check("armed", rd, 32'h1);
        axi_write(remap_pkg::OFF_LOCK, {20'h0, b, 11'h0}, 4'h3, rs);
    endtask : set_lock

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // the tests take a few hundred cycles; twenty thousand means a hang
    initial begin
        #(100 * 20000);
        n_fail++;
        test_done();
    end

    initial begin
        seed = 32'h0f79b04d;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, load} = '0;
        {awaddr, araddr, wdata, wstrb, level} = '0;
        for (int i = 0; i < 10; i++) shadow[i] = 16'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("periph reset", 32'(periph_in), 32'h0);
        for (int i = 0; i < 11; i++) begin
            axi_read(8'(4 * i), rd, rs);
            check("reset value", rd, 32'h0);
        end
        $display("test reset values done");
        for (int n = 0; n < 40; n++) begin
            idx = 8'(n % 10);
            val = (n < 20) ? corner[n % 4] : {8'($unsigned($random(seed)) % 81),
                                              8'($unsigned($random(seed)) % 81)};
            axi_write(8'(4 * idx), {16'h0, val}, 4'h3, rs);
            shadow[idx] = val;
            axi_read(8'(4 * idx), rd, rs);
            check("readback", rd, {16'h0, val});
            pins_and_routes(n[0] ? {$random(seed), $random(seed)} : {64{n[1]}});
        end
        $display("test random routes done");
        axi_write(remap_pkg::OFF_CAP7_TMR7, 32'h1234, 4'h2, rs);
        shadow[3][15:8] = 8'h12;
        axi_read(remap_pkg::OFF_CAP7_TMR7, rd, rs);
        check("upper lane", rd, {16'h0, shadow[3]});
        axi_write(8'h30, 32'h1, 4'h3, rs);
        check("bad addr wr", 32'(rs), 32'(remap_pkg::RESP_SLVERR));
        axi_read(8'h30, rd, rs);
        check("bad addr rd", {rd[29:0], rs}, 32'(remap_pkg::RESP_SLVERR));
        $display("test lanes and unmapped done");
        axi_write(remap_pkg::OFF_LOCK, 32'h800, 4'h3, rs);
        check("lock no keys", 32'(remap_lock), 32'h0);
        set_lock(1'b1);
        check("lock set", 32'(remap_lock), 32'h1);
        axi_write(remap_pkg::OFF_CAP4_TMR4, 32'h0505, 4'h3, rs);
        check("locked resp", 32'(rs), 32'(remap_pkg::RESP_OKAY));
        axi_read(remap_pkg::OFF_CAP4_TMR4, rd, rs);
        check("locked write", rd, {16'h0, shadow[0]});
        pins_and_routes({$random(seed), $random(seed)});
        set_lock(1'b0);
        check("lock clear", 32'(remap_lock), 32'h0);
        axi_write(remap_pkg::OFF_CAP4_TMR4, 32'h0505, 4'h3, rs);
        shadow[0] = 16'h0505;
        axi_read(remap_pkg::OFF_CAP4_TMR4, rd, rs);
        check("unlocked write", rd, 32'h0505);
        pins_and_routes({$random(seed), $random(seed)});
        $display("test lock done");
        test_done();
    end
endmodule : remappable_input_selector_bench
